/* File: ltmc_pkg.sv */
// Purpose: Shared constants for the LIN transceiver mode controller
// Assumes: 100 MHz system clock
// Notes:   Times in ns, us or ms as printed; cycle counts derived here
`default_nettype none
package ltmc_pkg;
   localparam int unsigned CLK_PERIOD_NS = 10;
   // Filter windows: least time rounded up to whole cycles
   localparam int unsigned ENABLE_FILTER_US = 11;
   localparam int unsigned ENABLE_FILTER_CYC = (ENABLE_FILTER_US * 1000 + CLK_PERIOD_NS - 1)
                                               / CLK_PERIOD_NS;
   localparam int unsigned DISABLE_FILTER_US = 11;
   localparam int unsigned DISABLE_FILTER_CYC = (DISABLE_FILTER_US * 1000 + CLK_PERIOD_NS - 1)
                                                / CLK_PERIOD_NS;
   localparam int unsigned WAKE_FILTER_US = 40;
   localparam int unsigned WAKE_FILTER_CYC = (WAKE_FILTER_US * 1000 + CLK_PERIOD_NS - 1)
                                             / CLK_PERIOD_NS;
   localparam int unsigned STANDBY_ENTRY_US = 5;
   localparam int unsigned STANDBY_ENTRY_CYC = (STANDBY_ENTRY_US * 1000 + CLK_PERIOD_NS - 1)
                                               / CLK_PERIOD_NS;
   localparam int unsigned TX_READY_US = 15;
   localparam int unsigned TX_READY_CYC = (TX_READY_US * 1000 + CLK_PERIOD_NS - 1)
                                          / CLK_PERIOD_NS;
   localparam int unsigned STUCK_DOM_MS = 14;
   localparam int unsigned STUCK_DOM_CYC = (STUCK_DOM_MS * 1000000 + CLK_PERIOD_NS - 1)
                                           / CLK_PERIOD_NS;
   localparam int unsigned CNT_W = 24;
   typedef enum logic [1:0] {
      ST_UNPOWERED,
      ST_SLEEP,
      ST_STANDBY,
      ST_NORMAL
   } ltmc_state_t;
endpackage : ltmc_pkg
`default_nettype wire

/* File: ltmc_filt_if.sv */
// Purpose: Carrier between the controller and its level filter
// Assumes: Same clock on both sides
// Notes:   One filter serves one input
`default_nettype none
interface ltmc_filt_if;
   logic                     level;
   logic                     armed;
   logic [ltmc_pkg::CNT_W-1:0] limit;
   logic                     done;
   modport ctl (output level, output armed, output limit, input done);
   modport flt (input level, input armed, input limit, output done);
endinterface : ltmc_filt_if
`default_nettype wire

/* File: ltmc_filter.sv */
// Purpose: Level persistence filter
// Assumes: Level already synchronised
// Notes:   Done pulses once when the level has held for limit cycles
`default_nettype none
module ltmc_filter (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Controller side
   ltmc_filt_if.flt  f
);
   logic [ltmc_pkg::CNT_W-1:0] cnt_reg;
   logic                       last_reg;
   wire                        restart = !f.armed || (f.level != last_reg);
   wire                        hit     = f.armed && !restart && (cnt_reg == f.limit - 1'b1);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_reg  <= '0;
         last_reg <= 1'b0;
      end else begin
         last_reg <= f.level;
         if (restart) cnt_reg <= '0;
         else if (cnt_reg != f.limit) cnt_reg <= cnt_reg + 1'b1;
      end
   end
   // Count restarts on any level change before completion
   assign f.done = hit;
endmodule : ltmc_filter
`default_nettype wire

/* File: ltmc_mode_ctrl.sv */
// Purpose: Mode and timing logic of a stand-alone LIN transceiver
// Assumes: 100 MHz clk; pins synchronised here; supply_ok from a POR comparator
// Notes:   Open-drain pins are given as out/enable pairs
`default_nettype none
module ltmc_mode_ctrl #(
   parameter int unsigned STUCK_CYC = ltmc_pkg::STUCK_DOM_CYC
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Supply monitor (level, low when below reset level)
   input  wire logic supply_ok,
   // Controller pins
   input  wire logic txd_in,
   input  wire logic mode_sel_in,
   output var  logic rxd_out,
   output var  logic rxd_oe,
   output var  logic txd_pd_strong,
   // Bus pin
   input  wire logic bus_in,
   output var  logic bus_out,
   output var  logic bus_oe,
   output var  logic bus_pullup_en,
   // Status
   output var  logic tx_ready,
   output var  logic [1:0] mode
);
   ////////////////////////////////////////////////////////////////////////////
   // Three-stage synchronisers; a change counts when stages two and three agree
   logic [2:0] sup_s, txd_s, en_s, bus_s;
   logic       sup_q, txd_q, en_q, bus_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sup_s <= 3'h0;
         txd_s <= 3'h7;
         en_s  <= 3'h0;
         bus_s <= 3'h7;
         sup_q <= 1'b0;
         txd_q <= 1'b1;
         en_q  <= 1'b0;
         bus_q <= 1'b1;
      end else begin
         sup_s <= {sup_s[1:0], supply_ok};
         txd_s <= {txd_s[1:0], txd_in};
         en_s  <= {en_s[1:0], mode_sel_in};
         bus_s <= {bus_s[1:0], bus_in};
         if (sup_s[1] == sup_s[2]) sup_q <= sup_s[2];
         if (txd_s[1] == txd_s[2]) txd_q <= txd_s[2];
         if (en_s[1] == en_s[2]) en_q <= en_s[2];
         if (bus_s[1] == bus_s[2]) bus_q <= bus_s[2];
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Filters
   ltmc_pkg::ltmc_state_t state_reg, state_next;
   ltmc_filt_if en_f ();
   ltmc_filt_if wk_f ();
   logic        wake_seen_reg;
   wire in_normal  = (state_reg == ltmc_pkg::ST_NORMAL);
   wire in_sleep   = (state_reg == ltmc_pkg::ST_SLEEP);
   wire in_standby = (state_reg == ltmc_pkg::ST_STANDBY);
   // Enable filter watches high in sleep and standby, low inside normal
   assign en_f.level = en_q;
   assign en_f.armed = in_normal ? !en_q : (in_sleep || in_standby) && en_q;
   assign en_f.limit = in_normal ? ltmc_pkg::CNT_W'(ltmc_pkg::DISABLE_FILTER_CYC)
                                 : ltmc_pkg::CNT_W'(ltmc_pkg::ENABLE_FILTER_CYC);
   assign wk_f.level = bus_q;
   assign wk_f.armed = in_sleep && !bus_q && !wake_seen_reg;
   assign wk_f.limit = ltmc_pkg::CNT_W'(ltmc_pkg::WAKE_FILTER_CYC);
   ltmc_filter u_en_filt (.clk(clk), .rst(rst), .f(en_f.flt));
   ltmc_filter u_wk_filt (.clk(clk), .rst(rst), .f(wk_f.flt));
   ////////////////////////////////////////////////////////////////////////////
   // Wake and standby-entry delay
   logic [ltmc_pkg::CNT_W-1:0] stb_cnt_reg;
   wire stb_go = wake_seen_reg && bus_q &&
                 (stb_cnt_reg == ltmc_pkg::CNT_W'(ltmc_pkg::STANDBY_ENTRY_CYC - 1));
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wake_seen_reg <= 1'b0;
         stb_cnt_reg   <= '0;
      end else if (!in_sleep) begin
         wake_seen_reg <= 1'b0;
         stb_cnt_reg   <= '0;
      end else begin
         if (wk_f.done) wake_seen_reg <= 1'b1;
         if (wake_seen_reg && bus_q) stb_cnt_reg <= stb_cnt_reg + 1'b1;
         else stb_cnt_reg <= '0;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // State machine
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ltmc_pkg::ST_UNPOWERED: if (sup_q) state_next = ltmc_pkg::ST_SLEEP;
         ltmc_pkg::ST_SLEEP: begin
            if (en_f.done) state_next = ltmc_pkg::ST_NORMAL;
            else if (stb_go) state_next = ltmc_pkg::ST_STANDBY;
         end
         ltmc_pkg::ST_STANDBY: if (en_f.done) state_next = ltmc_pkg::ST_NORMAL;
         ltmc_pkg::ST_NORMAL: if (en_f.done) state_next = ltmc_pkg::ST_SLEEP;
         default: state_next = ltmc_pkg::ST_UNPOWERED;
      endcase
      if (!sup_q) state_next = ltmc_pkg::ST_UNPOWERED;
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) state_reg <= ltmc_pkg::ST_UNPOWERED;
      else state_reg <= state_next;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Stuck-dominant timer; restarts on every high transmit input
   logic [ltmc_pkg::CNT_W-1:0] dom_cnt_reg;
   logic                       tx_lock_reg;
   logic [ltmc_pkg::CNT_W-1:0] rdy_cnt_reg;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dom_cnt_reg <= '0;
         tx_lock_reg <= 1'b0;
      end else if (!in_normal || txd_q) begin
         dom_cnt_reg <= '0;
         tx_lock_reg <= 1'b0;
      end else if (dom_cnt_reg == ltmc_pkg::CNT_W'(STUCK_CYC - 1)) begin
         tx_lock_reg <= 1'b1;
      end else begin
         dom_cnt_reg <= dom_cnt_reg + 1'b1;
      end
   end
   // Ready counter from mode-select rise; held at the limit
   wire rdy_hit = (rdy_cnt_reg == ltmc_pkg::CNT_W'(ltmc_pkg::TX_READY_CYC));
   always_ff @(posedge clk or posedge rst) begin
      if (rst) rdy_cnt_reg <= '0;
      else if (!en_q || state_reg == ltmc_pkg::ST_UNPOWERED) rdy_cnt_reg <= '0;
      else if (!rdy_hit) rdy_cnt_reg <= rdy_cnt_reg + 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Pin drive; rxd and bus are open-drain, driven only low
   wire drive_dom  = in_normal && rdy_hit && !txd_q && !tx_lock_reg;
   wire rxd_low    = (in_normal && !bus_q) || (in_standby && !en_q);
   wire pd_strong  = in_standby && !en_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bus_out       <= 1'b0;
         bus_oe        <= 1'b0;
         bus_pullup_en <= 1'b0;
         rxd_out       <= 1'b0;
         rxd_oe        <= 1'b0;
         txd_pd_strong <= 1'b0;
         tx_ready      <= 1'b0;
         mode          <= 2'h0;
      end else begin
         bus_out       <= 1'b0;
         bus_oe        <= drive_dom;
         bus_pullup_en <= in_normal || in_standby;
         rxd_out       <= 1'b0;
         rxd_oe        <= rxd_low;
         txd_pd_strong <= pd_strong;
         tx_ready      <= in_normal && rdy_hit;
         mode          <= state_reg;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   sequence s_unpowered;
      state_reg == ltmc_pkg::ST_UNPOWERED;
   endsequence
   a_unpowered_quiet: assert property (@(posedge clk) disable iff (rst)
      s_unpowered |=> !bus_oe && !rxd_oe && !txd_pd_strong)
      else $error("unpowered state drives a pin");
   a_supply_loss: assert property (@(posedge clk) disable iff (rst)
      !sup_q |=> s_unpowered)
      else $error("supply loss did not force unpowered");
   a_power_up_sleep: assert property (@(posedge clk) disable iff (rst)
      s_unpowered ##1 !(state_reg == ltmc_pkg::ST_UNPOWERED) |-> in_sleep)
      else $error("power up not to sleep");
   a_enable_filter: assert property (@(posedge clk) disable iff (rst)
      !in_normal ##1 in_normal |-> $past(en_q, 2) && en_q)
      else $error("normal entered without mode-select high");
   a_disable_filter: assert property (@(posedge clk) disable iff (rst)
      in_normal ##1 in_sleep |-> $past(!en_q, 2))
      else $error("sleep entered without mode-select low");
   a_wake_standby: assert property (@(posedge clk) disable iff (rst)
      in_sleep ##1 in_standby |-> $past(bus_q) && $past(wake_seen_reg))
      else $error("standby entered without wake and recessive bus");
   a_standby_rxd: assert property (@(posedge clk) disable iff (rst)
      in_standby && !en_q |=> rxd_oe)
      else $error("standby did not pull receive low");
   a_stuck_release: assert property (@(posedge clk) disable iff (rst)
      tx_lock_reg |=> !bus_oe)
      else $error("bus driven after stuck-dominant timeout");
   a_tx_ready: assert property (@(posedge clk) disable iff (rst)
      bus_oe |-> $past(rdy_hit))
      else $error("bus driven before transmitter ready");
endmodule : ltmc_mode_ctrl
`default_nettype wire

/* File: ltmc_bus_node.sv */
// Purpose: Far-side LIN bus with one remote node and the master pull-up
// Assumes: Bench drives remote_dom off the falling clock edge
// Notes:   A released bus floats up to recessive, so it never keeps a stale level
`default_nettype none
module ltmc_bus_node (
   // Device driver
   input  wire logic bus_out,
   input  wire logic bus_oe,
   // Remote node, high pulls the bus dominant
   input  wire logic remote_dom,
   // Resolved bus, low is dominant
   output var  logic bus_level
);
   timeunit 1ns;
   timeprecision 1ps;
   // Wired-AND: any driver beats the pull-up
   always_comb bus_level = (bus_oe ? bus_out : 1'b1) & !remote_dom;
endmodule : ltmc_bus_node
`default_nettype wire

/* File: lin_transceiver_mode_control_tb_top.sv */
// Purpose: Self-checking bench for the LIN transceiver mode controller
// Assumes: 100 MHz clk; bench acts as controller, bus node model as far side
// Notes:   Stuck limit shortened to 6000 cycles, still above one 20 kbps bit
`default_nettype none
module lin_transceiver_mode_control_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned STUCK = 6000;
   logic        clk, rst, supply_ok, txd_in, mode_sel_in, remote_dom, bus_level;
   logic        rxd_out, rxd_oe, txd_pd_strong, bus_out, bus_oe, bus_pullup_en, tx_ready;
   logic [1:0]  mode;
   logic [31:0] lfsr;
   logic [31:0] r;
   int          fail_count;
   int          checks;
   ////////////////////////////////////////////////////////////////////////////////
   ltmc_mode_ctrl #(.STUCK_CYC(STUCK)) i_ltmc_mode_ctrl (
      .clk(clk), .rst(rst), .supply_ok(supply_ok), .txd_in(txd_in),
      .mode_sel_in(mode_sel_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
      .txd_pd_strong(txd_pd_strong), .bus_in(bus_level), .bus_out(bus_out),
      .bus_oe(bus_oe), .bus_pullup_en(bus_pullup_en), .tx_ready(tx_ready), .mode(mode));
   ltmc_bus_node i_ltmc_bus_node (
      .bus_out(bus_out), .bus_oe(bus_oe), .remote_dom(remote_dom), .bus_level(bus_level));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next
   // Low on transmit means the device pulls the bus
   function automatic logic exp_drive(input logic txd);
      return !txd;
   endfunction : exp_drive
   // Bus is dominant when this node sends low or the remote node pulls it
   function automatic logic exp_rxd_low(input logic txd, input logic rem);
      return !txd || rem;
   endfunction : exp_rxd_low
   task automatic draw();
      lfsr = lfsr_next(lfsr);
      r = lfsr;
   endtask : draw
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc
   task automatic cmp_bit(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp_bit
   task automatic cmp_mode(input logic [1:0] got, input logic [1:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp_mode
   task automatic test_done();
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : test_done
   // Bounded wait; running out ends the run as a failure
   task automatic wait_mode(input logic [1:0] exp, input int max);
      for (int i = 0; i < max && mode !== exp; i++) @(negedge clk);
      cmp_mode(mode, exp);
      if (mode !== exp) test_done();
   endtask : wait_mode
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      lfsr = 32'hD06A55E9;
      r = 32'h0;
      fail_count = 0;
      checks = 0;
      rst = 1'b1;
      supply_ok = 1'b0;
      txd_in = 1'b1;
      mode_sel_in = 1'b0;
      remote_dom = 1'b0;
      cyc(20);
      rst = 1'b0;
      cyc(5);
      cmp_mode(mode, ltmc_pkg::ST_UNPOWERED);
      cmp_bit(bus_oe, 1'b0);
      cmp_bit(rxd_oe, 1'b0);
      cmp_bit(bus_pullup_en, 1'b0);
      supply_ok = 1'b1;
      wait_mode(ltmc_pkg::ST_SLEEP, 20);
      // Short enable pulse and short bus dominant must both be ignored
      draw();
      mode_sel_in = 1'b1;
      cyc(200 + r % 800);
      mode_sel_in = 1'b0;
      cyc(1300);
      cmp_mode(mode, ltmc_pkg::ST_SLEEP);
      draw();
      remote_dom = 1'b1;
      cyc(400 + r % 3400);
      remote_dom = 1'b0;
      cyc(700);
      cmp_mode(mode, ltmc_pkg::ST_SLEEP);
      // Remote wake-up
      remote_dom = 1'b1;
      cyc(4100);
      remote_dom = 1'b0;
      cyc(480);
      cmp_mode(mode, ltmc_pkg::ST_SLEEP);
      wait_mode(ltmc_pkg::ST_STANDBY, 60);
      cmp_bit(rxd_oe, 1'b1);
      cmp_bit(txd_pd_strong, 1'b1);
      cmp_bit(bus_pullup_en, 1'b1);
      mode_sel_in = 1'b1;
      cyc(8);
      cmp_bit(rxd_oe, 1'b0);
      cmp_bit(txd_pd_strong, 1'b0);
      cyc(1000);
      cmp_mode(mode, ltmc_pkg::ST_STANDBY);
      wait_mode(ltmc_pkg::ST_NORMAL, 120);
      cmp_bit(tx_ready, 1'b0);
      cyc(500);
      cmp_bit(tx_ready, 1'b1);
      // Random bits at 20 kbps, each closed by a short recessive gap
      for (int k = 0; k < 8; k++) begin
         draw();
         txd_in = (k == 0) ? 1'b0 : r[0];
         remote_dom = r[1] & txd_in;
         cyc(4990);
         cmp_bit(bus_oe, exp_drive(txd_in));
         cmp_bit(rxd_oe, exp_rxd_low(txd_in, remote_dom));
         cmp_bit(bus_out, 1'b0);
         cmp_bit(rxd_out, 1'b0);
         txd_in = 1'b1;
         remote_dom = 1'b0;
         cyc(10);
      end
      // Stuck dominant
      txd_in = 1'b0;
      cyc(STUCK - 200);
      cmp_bit(bus_oe, 1'b1);
      cyc(400);
      cmp_bit(bus_oe, 1'b0);
      cyc(50);
      cmp_bit(bus_oe, 1'b0);
      txd_in = 1'b1;
      cyc(10);
      txd_in = 1'b0;
      cyc(10);
      cmp_bit(bus_oe, 1'b1);
      txd_in = 1'b1;
      cyc(10);
      draw();
      mode_sel_in = 1'b0;
      cyc(200 + r % 800);
      mode_sel_in = 1'b1;
      cyc(1300);
      cmp_mode(mode, ltmc_pkg::ST_NORMAL);
      // Supply loss while driving dominant, then power-up with enable high
      // Ready counter restarted with the short low pulse; let it finish first
      cyc(300);
      txd_in = 1'b0;
      cyc(10);
      cmp_bit(bus_oe, 1'b1);
      supply_ok = 1'b0;
      wait_mode(ltmc_pkg::ST_UNPOWERED, 20);
      cmp_bit(bus_oe, 1'b0);
      cmp_bit(rxd_oe, 1'b0);
      cmp_bit(txd_pd_strong, 1'b0);
      supply_ok = 1'b1;
      wait_mode(ltmc_pkg::ST_SLEEP, 20);
      txd_in = 1'b1;
      wait_mode(ltmc_pkg::ST_NORMAL, 1200);
      mode_sel_in = 1'b0;
      cyc(1050);
      cmp_mode(mode, ltmc_pkg::ST_NORMAL);
      wait_mode(ltmc_pkg::ST_SLEEP, 150);
      test_done();
   end
endmodule : lin_transceiver_mode_control_tb_top
`default_nettype wire
